//--- common/acp_params.svh
`ifndef ACP_PARAMS_SVH
`define ACP_PARAMS_SVH

// register byte offsets on the apb window
`define ACP_CTRL_OFF        12'h000
`define ACP_TXQ_OFF         12'h004
`define ACP_RXQ_OFF         12'h008
`define ACP_STAT_OFF        12'h00c

// control register fields
`define ACP_BYTE_ORDER_BIT  31
`define ACP_SLAVE_ID_HI     28
`define ACP_SLAVE_ID_LO     24
`define ACP_TX_XHDR_HI      21
`define ACP_TX_XHDR_LO      18
`define ACP_TX_EN_BIT       16
`define ACP_MULTI_PHY_BIT   14
`define ACP_RX_XHDR_HI      5
`define ACP_RX_XHDR_LO      2
`define ACP_RX_EN_BIT       0
`define ACP_CTRL_WMASK      32'h9f3d_403d
`define ACP_CTRL_RESET      32'h0000_0000

// status register fields
`define ACP_STAT_TXLVL_HI   7
`define ACP_STAT_TXLVL_LO   0
`define ACP_STAT_RXLVL_HI   15
`define ACP_STAT_RXLVL_LO   8
`define ACP_STAT_TXBUSY_BIT 16
`define ACP_STAT_RXBUSY_BIT 17

// cell geometry
`define ACP_STD_CELL_BYTES  7'h35
`define ACP_SYNC_W          16

`endif

//--- common/acp_pkg.sv
package acp_pkg;

  // transmit serializer states
  typedef enum logic [0:0] {
    ACP_TX_IDLE,
    ACP_TX_SEND
  } acp_tx_state_e;

  typedef logic [31:0] acp_word_t;

endpackage

//--- verilog/acp_word_fifo.sv
`timescale 1ns/1ps

// word queue holding cell data between the bus and the link side
module acp_word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int LW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data,
  output logic [LW-1:0]         level
);
  localparam int AW = $clog2(DEPTH);

  if ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < 2) begin : g_bad_depth
    $error("acp_word_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [LW-1:0]    level_reg;
  logic             push;
  logic             pop;

  // handshake terms; a flush refuses both sides
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;
  assign wr_ready = ~clr & (level_reg != LW'(DEPTH));
  assign rd_valid = ~clr & (level_reg != '0);
  assign rd_data  = mem[rd_ptr_reg];
  assign level    = level_reg;

  // storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else if (clr) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level_reg  <= '0;
    end else begin
      wr_ptr_reg <= push ? wr_ptr_reg + AW'(1) : wr_ptr_reg;
      rd_ptr_reg <= pop ? rd_ptr_reg + AW'(1) : rd_ptr_reg;
      case ({push, pop})
        2'b10:   level_reg <= level_reg + LW'(1);
        2'b01:   level_reg <= level_reg - LW'(1);
        default: level_reg <= level_reg;
      endcase
    end
  end
endmodule

//--- verilog/acp_cell_port.sv
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "acp_params.svh"

// What this block does
// (RULE_01) bit 31 picks byte order of queue words; 1 big, 0 little; resets 0
// (RULE_02) reserved control bits read zero and ignore writes
// (RULE_03) bits 28:24 hold the 5-bit slave identity for multi-phy, reset 0
// (RULE_04) in single-phy mode the slave identity is ignored
// (RULE_05) software writes only 0..11 into the tx extra-header count
// (RULE_06) tx extra-header count 0 sends plain 53-byte cells
// (RULE_07) tx extra-header count n sends 53+n byte cells
// (RULE_08) tx enable bit 16 low holds the transmit side in reset
// (RULE_09) tx enable high releases the transmit side to run
// (RULE_10) both queues are reached through their own bus data ports
// (RULE_11) bit 14 picks single-phy (0) or multi-phy (1) for both sides
// (RULE_12) rx enable bit 0 low holds the receive side in reset
// (RULE_13) bits 5:2 give rx extra-header count; cells are 53+n bytes
// (RULE_14) tx and rx enables act on their own direction only
module acp_cell_port #(
  parameter int QDEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  link_addr,
  input  wire logic        tx_link_enb_n,
  output logic [7:0]       tx_byte_data,
  output logic             tx_byte_soc,
  output logic             tx_byte_valid,
  output logic             tx_cell_avail,
  input  wire logic [7:0]  rx_byte_data,
  input  wire logic        rx_byte_soc,
  input  wire logic        rx_byte_valid,
  output logic             rx_cell_room
);
  localparam int LW = $clog2(QDEPTH + 1);

  if (QDEPTH < 16 || QDEPTH > 128) begin : g_bad_qdepth
    $error("acp_cell_port: QDEPTH must hold a full cell and fit 8 bits");
  end

  // bytes in one cell for an extra-header count
  function automatic logic [6:0] cell_bytes(input logic [3:0] n);
    return `ACP_STD_CELL_BYTES + {3'h0, n};
  endfunction

  // queue words that one cell occupies
  function automatic logic [7:0] cell_words(input logic [3:0] n);
    logic [6:0] b;
    b = cell_bytes(n) + 7'h03;
    return {3'h0, b[6:2]};
  endfunction

  // bit offset of a byte lane inside a queue word
  function automatic logic [4:0] lane_shift(input logic big,
                                            input logic [1:0] lane);
    return big ? {~lane, 3'h0} : {lane, 3'h0};
  endfunction

  logic [31:0]               ctrl_reg;
  logic [31:0]               ctrl_next;
  logic [31:0]               prdata_reg;
  logic                      pready_reg;
  logic                      pslverr_reg;
  logic [`ACP_SYNC_W-1:0]    sync1_reg;
  logic [`ACP_SYNC_W-1:0]    sync2_reg;
  logic                      rx_valid_old_reg;
  acp_pkg::acp_tx_state_e    tx_state_reg;
  logic [6:0]                tx_cnt_reg;
  logic [7:0]                tx_byte_data_reg;
  logic                      tx_byte_soc_reg;
  logic                      tx_byte_valid_reg;
  logic                      tx_cell_avail_reg;
  logic                      rx_active_reg;
  logic [6:0]                rx_cnt_reg;
  logic [31:0]               rx_word_reg;
  logic                      rx_cell_room_reg;

  // control fields
  wire        byte_big   = ctrl_reg[`ACP_BYTE_ORDER_BIT];
  wire [4:0]  slave_id   = ctrl_reg[`ACP_SLAVE_ID_HI:`ACP_SLAVE_ID_LO];
  wire [3:0]  tx_xhdr    = ctrl_reg[`ACP_TX_XHDR_HI:`ACP_TX_XHDR_LO];
  wire        tx_en      = ctrl_reg[`ACP_TX_EN_BIT];
  wire        multi_phy  = ctrl_reg[`ACP_MULTI_PHY_BIT];
  wire [3:0]  rx_xhdr    = ctrl_reg[`ACP_RX_XHDR_HI:`ACP_RX_XHDR_LO];
  wire        rx_en      = ctrl_reg[`ACP_RX_EN_BIT];

  // synchronised link pins
  wire        enb_n_s    = sync2_reg[15];
  wire [4:0]  addr_s     = sync2_reg[14:10];
  wire        rx_valid_s = sync2_reg[9];
  wire        rx_soc_s   = sync2_reg[8];
  wire [7:0]  rx_data_s  = sync2_reg[7:0];

  // queue wiring
  logic              txq_wready;
  logic [31:0]       txq_rdata;
  logic [LW-1:0]     txq_level;
  logic              rxq_rvalid;
  logic [31:0]       rxq_rdata;
  logic [LW-1:0]     rxq_level;
  wire  [7:0]        txq_lvl8 = 8'(txq_level);
  wire  [7:0]        rxq_lvl8 = 8'(rxq_level);

  // apb decode; effects land on the completing edge
  wire apb_access = psel & penable & ~pready_reg;
  wire apb_done   = psel & penable & pready_reg;
  wire sel_ctrl   = paddr == `ACP_CTRL_OFF;
  wire sel_txq    = paddr == `ACP_TXQ_OFF;
  wire sel_rxq    = paddr == `ACP_RXQ_OFF;
  wire sel_stat   = paddr == `ACP_STAT_OFF;
  wire mapped     = sel_ctrl | sel_txq | sel_rxq | sel_stat;
  wire wr_ctrl    = apb_done & pwrite & sel_ctrl;
  wire txq_push   = apb_done & pwrite & sel_txq & txq_wready; // RULE_10
  wire rxq_pop    = apb_done & ~pwrite & sel_rxq & rxq_rvalid
                  & ~pslverr_reg; // RULE_10
  wire apb_err    = ~mapped | (pwrite & sel_txq & ~txq_wready)
                  | (~pwrite & sel_rxq & ~rxq_rvalid);

  // read data selection
  wire [31:0] stat_word = {14'h0, rx_active_reg,
                           tx_state_reg == acp_pkg::ACP_TX_SEND,
                           rxq_lvl8, txq_lvl8};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_reg :
                       sel_rxq  ? (rxq_rvalid ? rxq_rdata : 32'h0) :
                       sel_stat ? stat_word : 32'h0;

  // reserved positions masked off on write
  assign ctrl_next = wr_ctrl ? (pwdata & `ACP_CTRL_WMASK)
                             : ctrl_reg; // RULE_02

  // bus slave flops: one wait state per access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg    <= `ACP_CTRL_RESET; // RULE_01
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      pready_reg  <= apb_access;
      pslverr_reg <= apb_access & apb_err;
      if (apb_access) begin
        prdata_reg <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // two-flop synchroniser for link pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg        <= 16'h8000;
      sync2_reg        <= 16'h8000;
      rx_valid_old_reg <= 1'b0;
    end else begin
      sync1_reg        <= {tx_link_enb_n, link_addr, rx_byte_valid,
                           rx_byte_soc, rx_byte_data};
      sync2_reg        <= sync1_reg;
      rx_valid_old_reg <= rx_valid_s;
    end
  end

  // port selection; identity only counts in multi-phy mode
  wire id_hit = addr_s == slave_id; // RULE_03
  wire tx_sel = ~multi_phy | id_hit; // RULE_04 RULE_11
  wire rx_sel = ~multi_phy | id_hit; // RULE_04 RULE_11

  // transmit serializer terms
  wire [6:0] tx_len   = cell_bytes(tx_xhdr); // RULE_06 RULE_07
  wire       tx_ready = txq_lvl8 >= cell_words(tx_xhdr);
  wire       tx_start = tx_state_reg == acp_pkg::ACP_TX_IDLE & tx_en
                      & tx_sel & ~enb_n_s & tx_ready; // RULE_09
  wire       tx_fire  = tx_state_reg == acp_pkg::ACP_TX_SEND & ~enb_n_s;
  wire       tx_last  = tx_cnt_reg == tx_len - 7'h01;
  wire       txq_pop  = tx_fire & ((tx_cnt_reg[1:0] == 2'h3) | tx_last);
  wire [31:0] tx_shifted = txq_rdata >> lane_shift(byte_big, tx_cnt_reg[1:0]);

  // transmit state; disable holds everything in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= acp_pkg::ACP_TX_IDLE;
      tx_cnt_reg   <= 7'h0;
    end else if (!tx_en) begin
      tx_state_reg <= acp_pkg::ACP_TX_IDLE; // RULE_08 RULE_14
      tx_cnt_reg   <= 7'h0;
    end else begin
      case (tx_state_reg)
        acp_pkg::ACP_TX_IDLE: begin
          tx_cnt_reg <= 7'h0;
          if (tx_start) begin
            tx_state_reg <= acp_pkg::ACP_TX_SEND;
          end
        end
        acp_pkg::ACP_TX_SEND: begin
          if (tx_fire) begin
            tx_cnt_reg <= tx_last ? 7'h0 : tx_cnt_reg + 7'h01;
            if (tx_last) begin
              tx_state_reg <= acp_pkg::ACP_TX_IDLE; // RULE_07
            end
          end
        end
        default: tx_state_reg <= acp_pkg::ACP_TX_IDLE;
      endcase
    end
  end

  // transmit pin flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_byte_data_reg  <= 8'h0;
      tx_byte_soc_reg   <= 1'b0;
      tx_byte_valid_reg <= 1'b0;
      tx_cell_avail_reg <= 1'b0;
    end else begin
      tx_byte_valid_reg <= tx_en & tx_fire; // RULE_08
      tx_byte_soc_reg   <= tx_en & tx_fire & (tx_cnt_reg == 7'h0);
      tx_byte_data_reg  <= (tx_en & tx_fire) ? tx_shifted[7:0]
                                             : 8'h0; // RULE_01
      tx_cell_avail_reg <= tx_en & tx_sel & tx_ready;
    end
  end

  // receive assembler terms
  wire [6:0]  rx_len    = cell_bytes(rx_xhdr); // RULE_13
  wire        rx_strobe = rx_valid_s & ~rx_valid_old_reg & rx_en & rx_sel;
  wire        rx_take   = rx_strobe & (rx_soc_s | rx_active_reg);
  wire [6:0]  rx_idx    = rx_soc_s ? 7'h0 : rx_cnt_reg;
  wire        rx_last   = rx_idx == rx_len - 7'h01;
  wire [31:0] rx_base   = (rx_idx[1:0] == 2'h0) ? 32'h0 : rx_word_reg;
  wire [31:0] rx_merged = rx_base
                        | ({24'h0, rx_data_s}
                           << lane_shift(byte_big, rx_idx[1:0])); // RULE_01
  wire        rxq_push  = rx_take & ((rx_idx[1:0] == 2'h3) | rx_last);

  // receive state; disable holds it in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_active_reg <= 1'b0;
      rx_cnt_reg    <= 7'h0;
      rx_word_reg   <= 32'h0;
    end else if (!rx_en) begin
      rx_active_reg <= 1'b0; // RULE_12 RULE_14
      rx_cnt_reg    <= 7'h0;
      rx_word_reg   <= 32'h0;
    end else if (rx_take) begin
      rx_active_reg <= ~rx_last; // RULE_13
      rx_cnt_reg    <= rx_last ? 7'h0 : rx_idx + 7'h01;
      rx_word_reg   <= rx_merged;
    end
  end

  // receive room flag toward the master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_cell_room_reg <= 1'b0;
    end else begin
      rx_cell_room_reg <= rx_en & rx_sel
                        & ((8'(QDEPTH) - rxq_lvl8) >= cell_words(rx_xhdr));
    end
  end

  // transmit queue: bus fills, serializer drains
  acp_word_fifo #(
    .WIDTH (32),
    .DEPTH (QDEPTH)
  ) u_txq (
    .clk      (pclk),
    .rst_n    (presetn),
    .clr      (~tx_en),
    .wr_valid (txq_push),
    .wr_ready (txq_wready),
    .wr_data  (pwdata),
    .rd_valid (),
    .rd_ready (txq_pop),
    .rd_data  (txq_rdata),
    .level    (txq_level)
  );

  // receive queue: assembler fills, bus drains
  acp_word_fifo #(
    .WIDTH (32),
    .DEPTH (QDEPTH)
  ) u_rxq (
    .clk      (pclk),
    .rst_n    (presetn),
    .clr      (~rx_en),
    .wr_valid (rxq_push),
    .wr_ready (),
    .wr_data  (rx_merged),
    .rd_valid (rxq_rvalid),
    .rd_ready (rxq_pop),
    .rd_data  (rxq_rdata),
    .level    (rxq_level)
  );

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign tx_byte_data  = tx_byte_data_reg;
  assign tx_byte_soc   = tx_byte_soc_reg;
  assign tx_byte_valid = tx_byte_valid_reg;
  assign tx_cell_avail = tx_cell_avail_reg;
  assign rx_cell_room  = rx_cell_room_reg;

  // helper: bytes driven since the last start of cell
  logic [6:0] tx_seen_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_seen_reg <= 7'h0;
    end else if (tx_byte_valid_reg) begin
      tx_seen_reg <= tx_byte_soc_reg ? 7'h01 : tx_seen_reg + 7'h01;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_wait;
    psel && penable && !pready_reg;
  endsequence
  sequence s_apb_finish;
    pready_reg ##1 !pready_reg;
  endsequence

  a_ctrl_reserved_zero: assert property ( // RULE_02
    (ctrl_reg & ~`ACP_CTRL_WMASK) == 32'h0)
    else $error("reserved control bits not zero");
  a_ctrl_byte_order: assert property ( // RULE_01
    wr_ctrl |=> byte_big == $past(pwdata[31]))
    else $error("byte order bit not written");
  a_apb_one_wait: assert property (
    s_apb_wait |=> s_apb_finish)
    else $error("apb answer timing wrong");
  a_tx_held_off: assert property ( // RULE_08
    !tx_en |=> !tx_byte_valid_reg && tx_state_reg == acp_pkg::ACP_TX_IDLE)
    else $error("transmit active while disabled");
  a_tx_start_single: assert property ( // RULE_04
    tx_state_reg == acp_pkg::ACP_TX_IDLE && tx_en && !multi_phy
    && !enb_n_s && tx_ready |=> tx_state_reg == acp_pkg::ACP_TX_SEND)
    else $error("single-phy transmit did not start");
  a_tx_id_block: assert property ( // RULE_03
    tx_state_reg == acp_pkg::ACP_TX_IDLE && multi_phy && !id_hit
    |=> tx_state_reg == acp_pkg::ACP_TX_IDLE)
    else $error("transmit started for another identity");
  a_tx_cell_len: assert property ( // RULE_07
    $fell(tx_state_reg == acp_pkg::ACP_TX_SEND) && $past(tx_en) && tx_en
    && $stable(ctrl_reg) |=> tx_seen_reg == cell_bytes(tx_xhdr))
    else $error("transmitted cell length wrong");
  a_tx_indep: assert property ( // RULE_14
    !rx_en && tx_en && tx_fire |=> tx_byte_valid_reg)
    else $error("receive disable stalled transmit");
  a_rx_flush: assert property ( // RULE_12
    !rx_en |=> rxq_level == '0 && !rx_active_reg)
    else $error("receive side not held in reset");
  a_rx_cell_end: assert property ( // RULE_13
    rx_take && rx_last |=> !rx_active_reg ##1 rxq_level != '0)
    else $error("receive cell end not pushed");
  a_rxq_read: assert property ( // RULE_10
    rxq_pop |-> prdata_reg == rxq_rdata)
    else $error("receive queue read data wrong");
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`include "acp_params.svh"

module tb_top;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic [4:0]         link_addr = 5'h1f;
  logic               tx_link_enb_n = 1'b1;
  logic [7:0]         tx_byte_data;
  logic               tx_byte_soc;
  logic               tx_byte_valid;
  logic               tx_cell_avail;
  logic [7:0]         rx_byte_data = 8'h00;
  logic               rx_byte_soc = 1'b0;
  logic               rx_byte_valid = 1'b0;
  logic               rx_cell_room;
  int                 fail_count = 0;
  int                 check_count = 0;
  int                 soc_n = 0;
  logic [7:0]         txq[$];
  acp_pkg::acp_word_t rd;
  logic               err;

  acp_cell_port dut (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .link_addr     (link_addr),
    .tx_link_enb_n (tx_link_enb_n),
    .tx_byte_data  (tx_byte_data),
    .tx_byte_soc   (tx_byte_soc),
    .tx_byte_valid (tx_byte_valid),
    .tx_cell_avail (tx_cell_avail),
    .rx_byte_data  (rx_byte_data),
    .rx_byte_soc   (rx_byte_soc),
    .rx_byte_valid (rx_byte_valid),
    .rx_cell_room  (rx_cell_room)
  );

  // 200 mhz clock
  always #2.5 pclk = ~pclk;

  // collect every byte the transmitter puts on the link
  always @(posedge pclk) begin
    if (tx_byte_valid === 1'b1) begin
      txq.push_back(tx_byte_data);
      if (tx_byte_soc === 1'b1) soc_n++;
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    chk("pready wait", 32'(n), 32'h2);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  function automatic logic [7:0] bv(input int i);
    return 8'(i + 17);
  endfunction

  // queue word w of a cell of nb bytes, lanes in the chosen byte order
  function automatic acp_pkg::acp_word_t pack(input int w, input logic big,
                                              input int nb);
    acp_pkg::acp_word_t x;
    int k;
    x = 32'h0000_0000;
    for (k = 0; k < 4; k++) begin
      if (4 * w + k < nb) x[(big ? 3 - k : k) * 8 +: 8] = bv(4 * w + k);
    end
    return x;
  endfunction

  task automatic reg_test();
    apb(1'b0, `ACP_CTRL_OFF, 32'h0);
    chk("ctrl reset", rd, 32'h0000_0000);
    apb(1'b1, `ACP_CTRL_OFF, 32'hffc3_ffc3);
    apb(1'b0, `ACP_CTRL_OFF, 32'h0);
    chk("ctrl mask", rd, 32'h9f01_4001);
    apb(1'b1, `ACP_CTRL_OFF, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test registers done");
  endtask

  task automatic tx_cell(input logic big, input int n);
    int nb;
    int i;
    nb = 53 + n;
    apb(1'b1, `ACP_CTRL_OFF, {big, 9'h0, n[3:0], 2'b01, 16'h0});
    for (i = 0; i < (nb + 3) / 4; i++) begin
      apb(1'b1, `ACP_TXQ_OFF, pack(i, big, nb));
    end
    repeat (6) @(posedge pclk);
    chk("tx avail", {31'h0, tx_cell_avail}, 32'h1);
    txq.delete();
    soc_n = 0;
    tx_link_enb_n <= 1'b0;
    i = 0;
    while (txq.size() < nb && i < 400) begin
      @(posedge pclk);
      i++;
    end
    repeat (8) @(posedge pclk);
    chk("tx length", 32'(txq.size()), 32'(nb));
    chk("tx soc count", 32'(soc_n), 32'h1);
    for (i = 0; i < nb && i < txq.size(); i++) begin
      chk("tx byte", {24'h0, txq[i]}, {24'h0, bv(i)});
    end
    tx_link_enb_n <= 1'b1;
    chk("tx avail empty", {31'h0, tx_cell_avail}, 32'h0);
    $display("test tx cell done");
  endtask

  task automatic multi_phy_select_sel();
    int i;
    apb(1'b1, `ACP_CTRL_OFF, 32'h0501_4000);
    apb(1'b0, `ACP_CTRL_OFF, 32'h0);
    chk("slave id", rd, 32'h0501_4000);
    for (i = 0; i < 14; i++) apb(1'b1, `ACP_TXQ_OFF, pack(i, 1'b0, 53));
    link_addr <= 5'h03;
    repeat (6) @(posedge pclk);
    chk("other phy", {31'h0, tx_cell_avail}, 32'h0);
    link_addr <= 5'h05;
    repeat (6) @(posedge pclk);
    chk("own phy", {31'h0, tx_cell_avail}, 32'h1);
    apb(1'b1, `ACP_CTRL_OFF, 32'h0500_4000);
    repeat (4) @(posedge pclk);
    chk("tx off avail", {31'h0, tx_cell_avail}, 32'h0);
    chk("tx off valid", {31'h0, tx_byte_valid}, 32'h0);
    apb(1'b0, `ACP_STAT_OFF, 32'h0);
    chk("tx flushed", {24'h0, rd[7:0]}, 32'h0);
    link_addr <= 5'h1f;
    $display("test multi phy done");
  endtask

  // one byte into the receive side, with set-up and hold around valid
  task automatic rx_byte(input logic [7:0] d, input logic s);
    rx_byte_data <= d;
    rx_byte_soc <= s;
    repeat (3) @(posedge pclk);
    rx_byte_valid <= 1'b1;
    repeat (4) @(posedge pclk);
    rx_byte_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic rx_cell();
    int i;
    apb(1'b1, `ACP_CTRL_OFF, 32'h0);
    repeat (4) @(posedge pclk);
    chk("rx room off", {31'h0, rx_cell_room}, 32'h0);
    apb(1'b1, `ACP_CTRL_OFF, 32'h0001_0009);
    repeat (6) @(posedge pclk);
    chk("rx room on", {31'h0, rx_cell_room}, 32'h1);
    for (i = 0; i < 55; i++) begin
      if (i == 20) apb(1'b1, `ACP_CTRL_OFF, 32'h0000_0009);
      rx_byte(bv(i), i == 0);
    end
    apb(1'b0, `ACP_STAT_OFF, 32'h0);
    chk("rx level", {24'h0, rd[15:8]}, 32'h0000_000e);
    for (i = 0; i < 14; i++) begin
      apb(1'b0, `ACP_RXQ_OFF, 32'h0);
      chk("rx word", rd & (i == 13 ? 32'h00ff_ffff : 32'hffff_ffff),
          pack(i, 1'b0, 55));
    end
    apb(1'b0, `ACP_RXQ_OFF, 32'h0);
    chk("rx empty err", {31'h0, err}, 32'h1);
    $display("test rx cell done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    reg_test();
    tx_cell(1'b0, 0);
    tx_cell(1'b1, 11);
    multi_phy_select_sel();
    rx_cell();
    summarize();
  end

  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    summarize();
  end
endmodule
